// *** hdl/simd_fmt_pkg.sv ***
/*
 * constants for the packed-integer instruction format decoder and the
 * saturation / extension datapath.
 * assumes: one core clock domain, no software-visible registers.
 */
package simd_fmt_pkg;

	// ------------------------------------------------------------
	// encoding bytes
	// ------------------------------------------------------------
	localparam logic [7:0] ESCAPE_BYTE     = 8'h0f;
	localparam logic [7:0] OPC_EMPTY_STATE = 8'h77;
	localparam logic [7:0] OPC_MOVD_TO_PK  = 8'h6e;
	localparam logic [7:0] OPC_MOVD_FROM_PK = 8'h7e;
	localparam logic [7:0] OPC_MOVQ_TO_PK  = 8'h6f;
	localparam logic [7:0] OPC_MOVQ_FROM_PK = 8'h7f;
	localparam logic [7:0] OPC_PACK_SSWB   = 8'h63;
	localparam logic [7:0] OPC_PACK_SSDW   = 8'h6b;
	localparam logic [7:0] OPC_PACK_USWB   = 8'h67;
	// digit-form shift group with immediate byte
	localparam logic [7:0] OPC_SHIFT_W_IMM = 8'h71;
	localparam logic [7:0] OPC_SHIFT_D_IMM = 8'h72;
	localparam logic [7:0] OPC_SHIFT_Q_IMM = 8'h73;

	// ------------------------------------------------------------
	// modrm field positions
	// ------------------------------------------------------------
	localparam int MODRM_MOD_HI = 7;
	localparam int MODRM_MOD_LO = 6;
	localparam int MODRM_REG_HI = 5;
	localparam int MODRM_REG_LO = 3;
	localparam int MODRM_RM_HI  = 2;
	localparam int MODRM_RM_LO  = 0;
	localparam logic [1:0] MOD_REGISTER = 2'b11;
	localparam logic [2:0] RM_SIB       = 3'b100;
	localparam logic [2:0] RM_DISP32    = 3'b101;
	localparam logic [1:0] MOD_DISP8    = 2'b01;
	localparam logic [1:0] MOD_DISP32   = 2'b10;

	// ------------------------------------------------------------
	// tag word values
	// ------------------------------------------------------------
	localparam logic [15:0] TAG_ALL_EMPTY = 16'hffff;
	localparam logic [15:0] TAG_ALL_VALID = 16'h0000;
	localparam logic [15:0] TAG_RESET     = 16'hffff;

	// ------------------------------------------------------------
	// saturation bounds
	// ------------------------------------------------------------
	localparam logic [7:0]  S8_MIN  = 8'h80;
	localparam logic [7:0]  S8_MAX  = 8'h7f;
	localparam logic [15:0] S16_MIN = 16'h8000;
	localparam logic [15:0] S16_MAX = 16'h7fff;
	localparam logic [7:0]  U8_MAX  = 8'hff;
	localparam logic [15:0] U16_MAX = 16'hffff;

	// element size and arithmetic flavour
	typedef enum logic [1:0] {
		ELEM_BYTE  = 2'b00,
		ELEM_WORD  = 2'b01,
		ELEM_DWORD = 2'b10,
		ELEM_QWORD = 2'b11
	} elem_size_t;

	typedef enum logic [1:0] {
		ARITH_WRAP  = 2'b00,
		ARITH_SSAT  = 2'b01,
		ARITH_USAT  = 2'b10
	} arith_mode_t;

	// clamp selector for the datapath
	typedef enum logic [2:0] {
		CLAMP_S16_TO_S8 = 3'b000,
		CLAMP_S32_TO_S16 = 3'b001,
		CLAMP_S16_TO_U8 = 3'b010,
		CLAMP_RES_S8    = 3'b011,
		CLAMP_RES_S16   = 3'b100,
		CLAMP_RES_U8    = 3'b101,
		CLAMP_RES_U16   = 3'b110,
		CLAMP_NONE      = 3'b111
	} clamp_sel_t;

	// widening selector
	typedef enum logic [1:0] {
		WIDEN_ZERO = 2'b00,
		WIDEN_SIGN = 2'b01,
		WIDEN_PASS = 2'b10
	} widen_sel_t;

endpackage : simd_fmt_pkg

// *** hdl/simd_clamp_unit.sv ***
/*
 * saturation, clamping and widening of one 64-bit datapath word.
 * assumes: purely combinational, caller registers the result.
 */
`timescale 1ns/1ps

module simd_clamp_unit (
	input  wire logic [63:0]               wide_i,
	input  wire simd_fmt_pkg::clamp_sel_t  clamp_sel_i,
	input  wire simd_fmt_pkg::widen_sel_t  widen_sel_i,
	input  wire logic [5:0]                src_bits_i,
	output logic      [63:0]               result_o
);

	// ------------------------------------------------------------
	// clamp helpers: input is two's complement at 64 bits
	// ------------------------------------------------------------
	function automatic logic [15:0] clamp_signed(input logic signed [63:0] v,
	                                              input logic is_word);
		logic signed [63:0] lo;
		logic signed [63:0] hi;
		lo = is_word ? -64'sd32768 : -64'sd128;
		hi = is_word ? 64'sd32767 : 64'sd127;
		if (v < lo) begin
			clamp_signed = is_word ? simd_fmt_pkg::S16_MIN : {8'h00, simd_fmt_pkg::S8_MIN};
		end else if (v > hi) begin
			clamp_signed = is_word ? simd_fmt_pkg::S16_MAX : {8'h00, simd_fmt_pkg::S8_MAX};
		end else begin
			clamp_signed = is_word ? v[15:0] : {8'h00, v[7:0]};
		end
	endfunction : clamp_signed

	// unsigned bound: all zeros below, all ones above the width
	function automatic logic [15:0] clamp_unsigned(input logic signed [63:0] v,
	                                                input logic is_word);
		logic signed [63:0] hi;
		hi = is_word ? 64'sd65535 : 64'sd255;
		if (v < 64'sd0) begin
			clamp_unsigned = 16'h0000;
		end else if (v > hi) begin
			clamp_unsigned = is_word ? simd_fmt_pkg::U16_MAX : {8'h00, simd_fmt_pkg::U8_MAX};
		end else begin
			clamp_unsigned = is_word ? v[15:0] : {8'h00, v[7:0]};
		end
	endfunction : clamp_unsigned

	// sign-extended views of the source for the narrowing forms
	wire logic signed [63:0] s16_view = {{48{wide_i[15]}}, wide_i[15:0]};
	wire logic signed [63:0] s32_view = {{32{wide_i[31]}}, wide_i[31:0]};
	wire logic signed [63:0] res_view = wide_i;

	// widening: mask to source width then fill
	wire logic [63:0] low_mask = (src_bits_i == 6'd0) ? {64{1'b1}} : ~({64{1'b1}} << src_bits_i);
	wire logic [5:0]  sign_pos = src_bits_i - 6'd1;
	wire logic        sign_bit = (src_bits_i == 6'd0) ? 1'b0 : wide_i[sign_pos];
	wire logic [63:0] zext     = wide_i & low_mask;
	wire logic [63:0] sext     = zext | (sign_bit ? ~low_mask : 64'h0);

	logic [63:0] clamp_out;

	// clamp selection
	always_comb begin
		clamp_out = 64'h0;
		unique case (clamp_sel_i)
			simd_fmt_pkg::CLAMP_S16_TO_S8:  clamp_out = {48'h0, clamp_signed(s16_view, 1'b0)};
			simd_fmt_pkg::CLAMP_S32_TO_S16: clamp_out = {48'h0, clamp_signed(s32_view, 1'b1)};
			simd_fmt_pkg::CLAMP_S16_TO_U8:  clamp_out = {48'h0, clamp_unsigned(s16_view, 1'b0)};
			simd_fmt_pkg::CLAMP_RES_S8:     clamp_out = {48'h0, clamp_signed(res_view, 1'b0)};
			simd_fmt_pkg::CLAMP_RES_S16:    clamp_out = {48'h0, clamp_signed(res_view, 1'b1)};
			simd_fmt_pkg::CLAMP_RES_U8:     clamp_out = {48'h0, clamp_unsigned(res_view, 1'b0)};
			simd_fmt_pkg::CLAMP_RES_U16:    clamp_out = {48'h0, clamp_unsigned(res_view, 1'b1)};
			simd_fmt_pkg::CLAMP_NONE: begin
				unique case (widen_sel_i)
					simd_fmt_pkg::WIDEN_ZERO: clamp_out = zext;
					simd_fmt_pkg::WIDEN_SIGN: clamp_out = sext;
					default:                  clamp_out = wide_i;
				endcase
			end
		endcase
	end

	assign result_o = clamp_out;

endmodule : simd_clamp_unit

// *** hdl/simd_modrm_split.sv ***
/*
 * splits a modrm byte and works out which address bytes follow it.
 * assumes: 32-bit addressing, combinational, caller sequences bytes.
 */
`timescale 1ns/1ps

module simd_modrm_split (
	input  wire logic [7:0] modrm_i,
	output logic      [1:0] mod_o,
	output logic      [2:0] reg_o,
	output logic      [2:0] rm_o,
	output logic            is_reg_o,
	output logic            has_sib_o,
	output logic      [2:0] disp_len_o
);

	// field extraction
	assign mod_o = modrm_i[simd_fmt_pkg::MODRM_MOD_HI:simd_fmt_pkg::MODRM_MOD_LO];
	assign reg_o = modrm_i[simd_fmt_pkg::MODRM_REG_HI:simd_fmt_pkg::MODRM_REG_LO];
	assign rm_o  = modrm_i[simd_fmt_pkg::MODRM_RM_HI:simd_fmt_pkg::MODRM_RM_LO];
	assign is_reg_o = (mod_o == simd_fmt_pkg::MOD_REGISTER);

	// every addressing mode, sib included; the disp32 after a sib with base 101 and mod 00 is left to the caller
	assign has_sib_o = !is_reg_o && (rm_o == simd_fmt_pkg::RM_SIB);
	assign disp_len_o = (mod_o == simd_fmt_pkg::MOD_DISP8) ? 3'd1 :
	                    (mod_o == simd_fmt_pkg::MOD_DISP32) ? 3'd4 :
	                    (mod_o == 2'b00 && rm_o == simd_fmt_pkg::RM_DISP32) ? 3'd4 : 3'd0;

endmodule : simd_modrm_split

// *** hdl/simd_format_decoder.sv ***
/*
 * byte-serial format decoder for packed-integer instructions plus the
 * saturation datapath and the tag word it owns.
 * assumes: fetch presents instruction bytes one per cycle in memory
 * order with valid/ready; the address unit sees every sib/disp byte.
 */
// Overview of operation
// - every instruction opens with escape 0f; all but empty-state carry modrm
// - non-transfer results go to packed regs; transfers may use integer regs
// - memory operands accept every addressing mode including sib
// - right operand is source, left is destination, result overwrites destination
// - memory address points at the least significant byte
// - condition flags stay unchanged by every packed instruction
// - digit forms use only r/m; reg field extends the opcode
// - register forms take one operand from reg and one from r/m
// - immediate byte follows opcode, modrm and sib; it is always zero-extended
// - signed immediate byte spans -128 to +127
// - 32-bit source is low half or mem32; 64-bit is full or mem64
// - zero widening fills upper bits with zeros, passes equal size
// - sign widening replicates sign bit, passes equal size
// - signed word to signed byte clamps to 0x80 and 0x7f
// - signed dword to signed word clamps to 0x8000 and 0x7fff
// - signed word to unsigned byte clamps to 0x00 and 0xff
// - signed byte result saturation clamps to -128 and 127
// - signed word result saturation clamps to 0x8000 and 0x7fff
// - unsigned byte result saturation clamps to zero and 0xff
// - unsigned word result saturation clamps to zero and 0xffff
// - decode wraparound, signed and unsigned saturation and all element sizes
// - opcode bytes are consumed in memory order
// - empty-state loads tag word all ones; others load all zeros
`timescale 1ns/1ps

module simd_format_decoder (
	input  wire logic                        sys_clk_i,
	input  wire logic                        rst_n_i,
	// instruction byte stream
	input  wire logic [7:0]                  byte_i,
	input  wire logic                        byte_valid_i,
	output logic                             byte_ready_o,
	// decoded instruction
	output logic                             dec_valid_o,
	output logic      [7:0]                  dec_opcode_o,
	output logic                             dec_illegal_o,
	output logic      [2:0]                  dec_dst_reg_o,
	output logic      [2:0]                  dec_src_reg_o,
	output logic                             dec_src_is_mem_o,
	output logic                             dec_src_is_imm_o,
	output logic                             dec_int_side_o,
	output logic                             dec_to_packed_o,
	output logic      [2:0]                  dec_ext_digit_o,
	output logic                             dec_src_is32_o,
	output logic      [63:0]                 dec_imm_o,
	output simd_fmt_pkg::elem_size_t         dec_elem_o,
	output simd_fmt_pkg::arith_mode_t        dec_arith_o,
	output logic                             dec_flags_we_o,
	output logic                             dec_mem_lsb_o,
	output logic      [15:0]                 tag_word_o,
	// saturation datapath
	input  wire logic [63:0]                 dp_value_i,
	input  wire simd_fmt_pkg::clamp_sel_t    dp_clamp_i,
	input  wire simd_fmt_pkg::widen_sel_t    dp_widen_i,
	input  wire logic [5:0]                  dp_src_bits_i,
	output logic      [63:0]                 dp_result_o
);

	// ------------------------------------------------------------
	// sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_ESCAPE = 3'b000,
		ST_OPCODE = 3'b001,
		ST_MODRM  = 3'b010,
		ST_SIB    = 3'b011,
		ST_DISP   = 3'b100,
		ST_IMM    = 3'b101,
		ST_DONE   = 3'b110
	} dec_state_t;

	dec_state_t  state_q, state_d;
	logic [7:0]  opcode_q;
	logic [7:0]  modrm_q;
	logic [2:0]  disp_left_q;
	logic [7:0]  imm_q;
	logic        illegal_q;
	logic [15:0] tag_q;
	logic [63:0] dp_q;

	wire logic take = byte_valid_i && byte_ready_o;

	// ------------------------------------------------------------
	// opcode classes
	// ------------------------------------------------------------
	wire logic op_empty = (opcode_q == simd_fmt_pkg::OPC_EMPTY_STATE);
	wire logic op_digit = (opcode_q == simd_fmt_pkg::OPC_SHIFT_W_IMM)
	                   || (opcode_q == simd_fmt_pkg::OPC_SHIFT_D_IMM)
	                   || (opcode_q == simd_fmt_pkg::OPC_SHIFT_Q_IMM);
	wire logic op_movd  = (opcode_q == simd_fmt_pkg::OPC_MOVD_TO_PK)
	                   || (opcode_q == simd_fmt_pkg::OPC_MOVD_FROM_PK);
	wire logic op_from  = (opcode_q == simd_fmt_pkg::OPC_MOVD_FROM_PK)
	                   || (opcode_q == simd_fmt_pkg::OPC_MOVQ_FROM_PK);
	wire logic op_xfer  = op_movd || op_from || (opcode_q == simd_fmt_pkg::OPC_MOVQ_TO_PK);
	// low opcode bits pick the element size
	wire logic [1:0] low2 = opcode_q[1:0];
	wire logic [3:0] hi4  = opcode_q[7:4];

	wire logic [1:0] m_mod;
	wire logic [2:0] m_reg;
	wire logic [2:0] m_rm;
	wire logic       m_is_reg;
	wire logic [2:0] m_disp;

	// modrm split
	simd_modrm_split u_modrm (
		.modrm_i    (modrm_q),
		.mod_o      (m_mod),
		.reg_o      (m_reg),
		.rm_o       (m_rm),
		.is_reg_o   (m_is_reg),
		.has_sib_o  (),
		.disp_len_o (m_disp)
	);

	wire logic       in_sib;
	wire logic [2:0] in_disp;
	// the same split on the arriving byte picks the next state
	simd_modrm_split u_modrm_in (
		.modrm_i    (byte_i),
		.mod_o      (),
		.reg_o      (),
		.rm_o       (),
		.is_reg_o   (),
		.has_sib_o  (in_sib),
		.disp_len_o (in_disp)
	);
	// sib with base 101 and mod 00 still brings a 32-bit displacement
	wire logic sib_disp = (m_mod == 2'b00) && (byte_i[2:0] == simd_fmt_pkg::RM_DISP32);
	wire dec_state_t after_addr = op_digit ? ST_IMM : ST_DONE;

	// next state: strict byte order escape, opcode, modrm, sib, disp, imm
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_ESCAPE: if (take) state_d = ST_OPCODE;
			ST_OPCODE: if (take) state_d = (byte_i == simd_fmt_pkg::OPC_EMPTY_STATE) ? ST_DONE : ST_MODRM;
			ST_MODRM:  if (take) state_d = in_sib ? ST_SIB : (in_disp != 3'd0) ? ST_DISP : after_addr;
			ST_SIB:    if (take) state_d = ((m_disp != 3'd0) || sib_disp) ? ST_DISP : after_addr;
			ST_DISP:   if (take && disp_left_q == 3'd1) state_d = after_addr;
			ST_IMM:    if (take) state_d = ST_DONE;
			ST_DONE:   state_d = ST_ESCAPE;
			default:   state_d = ST_ESCAPE;
		endcase
	end

	// sequencer registers
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			state_q     <= ST_ESCAPE;
			opcode_q    <= 8'h00;
			modrm_q     <= 8'h00;
			disp_left_q <= 3'd0;
			imm_q       <= 8'h00;
			illegal_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			if (take && state_q == ST_ESCAPE) illegal_q <= (byte_i != simd_fmt_pkg::ESCAPE_BYTE);
			if (take && state_q == ST_OPCODE) opcode_q <= byte_i;
			if (take && state_q == ST_MODRM) modrm_q <= byte_i;
			if (take && state_q == ST_MODRM) disp_left_q <= in_disp;
			if (take && state_q == ST_SIB && sib_disp) disp_left_q <= 3'd4;
			if (take && state_q == ST_DISP) disp_left_q <= disp_left_q - 3'd1;
			if (take && state_q == ST_IMM) imm_q <= byte_i;
		end
	end

	// stall input while presenting a result; one byte per cycle otherwise
	assign byte_ready_o = (state_q != ST_DONE);

	// ------------------------------------------------------------
	// tag word: only legal, completed instructions touch it
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			tag_q <= simd_fmt_pkg::TAG_RESET;
		end else if (state_q == ST_DONE && !illegal_q) begin
			tag_q <= op_empty ? simd_fmt_pkg::TAG_ALL_EMPTY : simd_fmt_pkg::TAG_ALL_VALID;
		end
	end

	// ------------------------------------------------------------
	// operand routing
	// ------------------------------------------------------------
	// reg field is the packed side; r/m is the other, to-forms put it on the right
	wire logic [2:0] dst_sel = op_digit ? m_rm : (op_from ? m_rm : m_reg);
	wire logic [2:0] src_sel = op_digit ? m_rm : (op_from ? m_reg : m_rm);
	// shift counts are unsigned; nothing else here takes an immediate byte
	wire logic imm_signed = 1'b0;
	wire logic [63:0] imm_ext = imm_signed ? {{56{imm_q[7]}}, imm_q} : {56'h0, imm_q};

	// element size and arithmetic flavour from the opcode row
	wire logic is_pack = (opcode_q == simd_fmt_pkg::OPC_PACK_SSWB)
	                  || (opcode_q == simd_fmt_pkg::OPC_PACK_SSDW)
	                  || (opcode_q == simd_fmt_pkg::OPC_PACK_USWB);
	wire logic row_sat = (hi4 == 4'hd || hi4 == 4'he) && (opcode_q[3:2] == 2'b10
	                  || opcode_q[3:2] == 2'b11);
	wire simd_fmt_pkg::arith_mode_t arith =
		(opcode_q == simd_fmt_pkg::OPC_PACK_USWB) ? simd_fmt_pkg::ARITH_USAT :
		is_pack ? simd_fmt_pkg::ARITH_SSAT :
		(row_sat && hi4 == 4'hd) ? simd_fmt_pkg::ARITH_USAT :
		row_sat ? simd_fmt_pkg::ARITH_SSAT : simd_fmt_pkg::ARITH_WRAP;
	wire simd_fmt_pkg::elem_size_t elem =
		(opcode_q == simd_fmt_pkg::OPC_PACK_SSDW) ? simd_fmt_pkg::ELEM_DWORD :
		is_pack ? simd_fmt_pkg::ELEM_WORD :
		op_movd ? simd_fmt_pkg::ELEM_DWORD :
		op_xfer ? simd_fmt_pkg::ELEM_QWORD :
		simd_fmt_pkg::elem_size_t'(low2);

	// decoded outputs, held while the result is presented
	assign dec_valid_o      = (state_q == ST_DONE);
	assign dec_opcode_o     = opcode_q;
	assign dec_illegal_o    = illegal_q;
	assign dec_dst_reg_o    = dst_sel;
	assign dec_src_reg_o    = src_sel;
	assign dec_src_is_mem_o = !op_empty && !m_is_reg;
	assign dec_src_is_imm_o = op_digit;
	assign dec_int_side_o   = op_movd;
	assign dec_to_packed_o  = !op_from;
	assign dec_ext_digit_o  = op_digit ? m_reg : 3'd0;
	assign dec_src_is32_o   = op_movd;
	assign dec_imm_o        = imm_ext;
	assign dec_elem_o       = elem;
	assign dec_arith_o      = arith;
	assign dec_flags_we_o   = 1'b0;
	assign dec_mem_lsb_o    = !op_empty && !m_is_reg;
	assign tag_word_o       = tag_q;

	// ------------------------------------------------------------
	// saturation datapath, registered one cycle
	// ------------------------------------------------------------
	wire logic [63:0] clamp_res;

	simd_clamp_unit u_clamp (
		.wide_i      (dp_value_i),
		.clamp_sel_i (dp_clamp_i),
		.widen_sel_i (dp_widen_i),
		.src_bits_i  (dp_src_bits_i),
		.result_o    (clamp_res)
	);

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			dp_q <= 64'h0;
		end else begin
			dp_q <= clamp_res;
		end
	end

	assign dp_result_o = dp_q;

endmodule : simd_format_decoder

// *** bench/simd_fetch_model.sv ***
/*
 * fetch-side model: offers instruction bytes with valid/ready, fast or
 * with an idle cycle after every byte.
 * assumes: the bench queues bytes with push; inputs change at falling edges.
 */
`timescale 1ns/1ps

module simd_fetch_model (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       byte_ready_o,
	input  wire logic       slow_i,
	output logic      [7:0] byte_i,
	output logic            byte_valid_i
);
	logic [7:0] pend_q[$];
	logic       taken_q;

	task automatic push(input logic [7:0] b);
		pend_q.push_back(b);
	endtask : push

	initial begin
		byte_i = 8'h00;
		byte_valid_i = 1'b0;
		taken_q = 1'b0;
	end

	always @(posedge sys_clk_i) taken_q <= rst_n_i && byte_valid_i && byte_ready_o;

	// hold a byte until taken; an idle line toggles so no stale value reads as valid
	always @(negedge sys_clk_i) begin
		if (!byte_valid_i || taken_q) begin
			if (rst_n_i && pend_q.size() != 0 && !(slow_i && byte_valid_i)) begin
				byte_i <= pend_q.pop_front();
				byte_valid_i <= 1'b1;
			end else begin
				byte_i <= ~byte_i;
				byte_valid_i <= 1'b0;
			end
		end
	end
endmodule : simd_fetch_model

// *** bench/simd_format_decoder_chk.sv ***
/*
 * concurrent checks on the packed format decoder and clamp datapath.
 * assumes: bound into simd_format_decoder; one clock, sync reset.
 */
`timescale 1ns/1ps

module simd_format_decoder_chk (
	input wire logic                     sys_clk_i,
	input wire logic                     rst_n_i,
	input wire logic                     dec_valid_o,
	input wire logic [7:0]               dec_opcode_o,
	input wire logic                     dec_illegal_o,
	input wire logic                     dec_src_is_mem_o,
	input wire logic                     dec_mem_lsb_o,
	input wire logic                     dec_flags_we_o,
	input wire logic [15:0]              tag_word_o,
	input wire logic [63:0]              dp_value_i,
	input wire simd_fmt_pkg::clamp_sel_t dp_clamp_i,
	input wire logic [63:0]              dp_result_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	// ------------------------------------------------------------
	// decode side
	// ------------------------------------------------------------
	a_flags_never_written: assert property (dec_flags_we_o == 1'b0)
		else $error("flag write strobe raised");
	a_empty_tag_ones: assert property (dec_valid_o && !dec_illegal_o &&
		dec_opcode_o == simd_fmt_pkg::OPC_EMPTY_STATE |=> tag_word_o == 16'hffff)
		else $error("empty-state did not load tag ones");
	a_other_tag_zero: assert property (dec_valid_o && !dec_illegal_o &&
		dec_opcode_o != simd_fmt_pkg::OPC_EMPTY_STATE |=> tag_word_o == 16'h0000)
		else $error("packed op did not clear tag word");
	a_illegal_tag_keep: assert property (dec_valid_o && dec_illegal_o |=>
		$stable(tag_word_o)) else $error("tag changed on bad escape");
	a_mem_lsb_addr: assert property (dec_valid_o |->
		dec_mem_lsb_o == dec_src_is_mem_o) else $error("memory lsb flag wrong");

	// ------------------------------------------------------------
	// clamp datapath, result one edge after inputs
	// ------------------------------------------------------------
	a_clamp_s8_high: assert property (dp_clamp_i == simd_fmt_pkg::CLAMP_S16_TO_S8 &&
		$signed(dp_value_i[15:0]) > 16'sd127 |=> dp_result_o[7:0] == 8'h7f)
		else $error("s16 to s8 high clamp wrong");
	a_clamp_s16_low: assert property (dp_clamp_i == simd_fmt_pkg::CLAMP_S32_TO_S16 &&
		$signed(dp_value_i[31:0]) < -32'sd32768 |=> dp_result_o[15:0] == 16'h8000)
		else $error("s32 to s16 low clamp wrong");
	a_clamp_u8_neg: assert property (dp_clamp_i == simd_fmt_pkg::CLAMP_S16_TO_U8 &&
		dp_value_i[15] |=> dp_result_o[7:0] == 8'h00) else $error("negative to u8 not zero");

	c_empty_state: cover property (dec_valid_o && dec_opcode_o == 8'h77);
	c_mem_operand: cover property (dec_valid_o && dec_src_is_mem_o);
	c_res_u16: cover property (dp_clamp_i == simd_fmt_pkg::CLAMP_RES_U16);
endmodule : simd_format_decoder_chk

bind simd_format_decoder simd_format_decoder_chk u_chk (.sys_clk_i, .rst_n_i, .dec_valid_o,
	.dec_opcode_o, .dec_illegal_o, .dec_src_is_mem_o, .dec_mem_lsb_o, .dec_flags_we_o,
	.tag_word_o, .dp_value_i, .dp_clamp_i, .dp_result_o);

// *** bench/testbench.sv ***
/*
 * self-checking bench: instruction bytes through the fetch model, clamp
 * rows straight into the datapath.
 * assumes: 250 MHz clock, inputs driven at falling edges.
 */
`timescale 1ns/1ps

module testbench;
	localparam logic [63:0] M8 = 64'hff;
	localparam logic [63:0] M16 = 64'hffff;
	logic        sys_clk_i, rst_n_i, slow_i, byte_valid_i, byte_ready_o, dec_valid_o;
	logic        dec_illegal_o, dec_src_is_mem_o, dec_src_is_imm_o, dec_int_side_o;
	logic        dec_to_packed_o, dec_src_is32_o, dec_flags_we_o, dec_mem_lsb_o;
	logic [7:0]  byte_i, dec_opcode_o;
	logic [2:0]  dec_dst_reg_o, dec_src_reg_o, dec_ext_digit_o;
	logic [15:0] tag_word_o;
	logic [63:0] dec_imm_o, dp_value_i, dp_result_o;
	logic [5:0]  dp_src_bits_i;
	simd_fmt_pkg::elem_size_t  dec_elem_o;
	simd_fmt_pkg::arith_mode_t dec_arith_o;
	simd_fmt_pkg::clamp_sel_t  dp_clamp_i;
	simd_fmt_pkg::widen_sel_t  dp_widen_i;
	int          num_errors = 0, n_checks = 0, cycles = 0;

	simd_fetch_model fetch (.sys_clk_i, .rst_n_i, .byte_ready_o, .slow_i, .byte_i, .byte_valid_i);
	simd_format_decoder dut (.sys_clk_i, .rst_n_i, .byte_i, .byte_valid_i, .byte_ready_o,
		.dec_valid_o, .dec_opcode_o, .dec_illegal_o, .dec_dst_reg_o, .dec_src_reg_o,
		.dec_src_is_mem_o, .dec_src_is_imm_o, .dec_int_side_o, .dec_to_packed_o,
		.dec_ext_digit_o, .dec_src_is32_o, .dec_imm_o, .dec_elem_o, .dec_arith_o,
		.dec_flags_we_o, .dec_mem_lsb_o, .tag_word_o, .dp_value_i, .dp_clamp_i,
		.dp_widen_i, .dp_src_bits_i, .dp_result_o);

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic send(input logic [7:0] b[$]);
		foreach (b[i]) fetch.push(b[i]);
	endtask : send

	// bounded wait; steps at least one edge
	task automatic wait_dec();
		int n = 0;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (dec_valid_o !== 1'b1 && n < 60);
		chk("dec_valid", {dec_valid_o, byte_ready_o}, 2'b10);
	endtask : wait_dec

	task automatic dp(input logic [2:0] c, input logic [63:0] v, input logic [63:0] e,
		input logic [63:0] m, input logic [1:0] w = 2'h2, input logic [5:0] b = 6'h00);
		dp_clamp_i = simd_fmt_pkg::clamp_sel_t'(c);
		dp_widen_i = simd_fmt_pkg::widen_sel_t'(w);
		dp_src_bits_i = b;
		dp_value_i = v;
		@(negedge sys_clk_i);
		chk("dp_result", dp_result_o & m, e);
	endtask : dp

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_tag_word();
		send('{8'h0f, 8'h77, 8'h0f, 8'hfc, 8'hc1});
		chk("tag_reset", tag_word_o, 16'hffff);
		wait_dec();
		chk("opcode", dec_opcode_o, 8'h77);
		wait_dec();
		chk("dst_reg", dec_dst_reg_o, 3'h0);
		chk("src_reg", dec_src_reg_o, 3'h1);
		@(negedge sys_clk_i);
		chk("tag_valid", tag_word_o, 16'h0000);
		$display("t_tag_word done");
	endtask : t_tag_word

	// slow feeder: digit form with immediate, sib+disp8 and disp32 memory forms
	task automatic t_operands();
		slow_i = 1'b1;
		send('{8'h0f, 8'h71, 8'hf2, 8'h05, 8'h0f, 8'h6e, 8'h44, 8'h24, 8'h08});
		send('{8'h0f, 8'h6f, 8'h04, 8'h25, 8'h11, 8'h22, 8'h33, 8'h44});
		send('{8'h0f, 8'h7f, 8'h05, 8'h11, 8'h22, 8'h33, 8'h44});
		wait_dec();
		chk("digit", dec_ext_digit_o, 3'h6);
		chk("imm", {dec_src_is_imm_o, dec_imm_o}, {1'b1, 64'h5});
		wait_dec();
		chk("sib_mem", {dec_src_is_mem_o, dec_int_side_o, dec_to_packed_o}, 3'b111);
		chk("src32", dec_src_is32_o, 1'b1);
		wait_dec();
		chk("sib_d32", {dec_opcode_o, dec_src_is_mem_o}, {8'h6f, 1'b1});
		wait_dec();
		chk("store", {dec_opcode_o, dec_src_is_mem_o, dec_to_packed_o}, {8'h7f, 2'b10});
		chk("src64", dec_src_is32_o, 1'b0);
		slow_i = 1'b0;
		$display("t_operands done");
	endtask : t_operands

	task automatic t_modes();
		logic [7:0] op[4] = '{8'hfe, 8'hdd, 8'hec, 8'hd8};
		logic [3:0] ex[4] = '{4'h8, 4'h6, 4'h1, 4'h2};
		foreach (op[i]) begin
			send('{8'h0f, op[i], 8'hc1});
			wait_dec();
			chk("elem_arith", {dec_elem_o, dec_arith_o}, ex[i]);
		end
		send('{8'h90, 8'h77});
		wait_dec();
		chk("illegal", dec_illegal_o, 1'b1);
		@(negedge sys_clk_i);
		chk("tag_kept", tag_word_o, 16'h0000);
		$display("t_modes done");
	endtask : t_modes

	task automatic t_clamps();
		dp(3'h0, 64'hff00, 64'h80, M8);
		dp(3'h0, 64'h0042, 64'h42, M8);
		dp(3'h0, 64'h0080, 64'h7f, M8);
		dp(3'h1, 64'hfffe0000, 64'h8000, M16);
		dp(3'h1, 64'h10000, 64'h7fff, M16);
		dp(3'h2, 64'hffff, 64'h00, M8);
		dp(3'h2, 64'h0100, 64'hff, M8);
		dp(3'h3, 64'hffffffffffffff7f, 64'h80, M8);
		dp(3'h3, 64'h80, 64'h7f, M8);
		dp(3'h4, 64'hffffffffffff7fff, 64'h8000, M16);
		dp(3'h4, 64'h8000, 64'h7fff, M16);
		dp(3'h5, '1, 64'h00, M8);
		dp(3'h5, 64'h100, 64'hff, M8);
		dp(3'h6, '1, 64'h0000, M16);
		dp(3'h6, 64'h10000, 64'hffff, M16);
		dp(3'h7, 64'haaaaaaaa80000001, 64'h80000001, '1, 2'h0, 6'h20);
		dp(3'h7, 64'hf6, 64'hfffffffffffffff6, '1, 2'h1, 6'h08);
		dp(3'h7, 64'h8000000000000001, 64'h8000000000000001, '1, 2'h1, 6'h00);
		$display("t_clamps done");
	endtask : t_clamps

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	// hang guard: a clean run takes well under 200 cycles
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			final_report();
		end
	end

	initial begin
		rst_n_i = 1'b0;
		slow_i = 1'b0;
		dp_value_i = '0;
		dp_clamp_i = simd_fmt_pkg::CLAMP_NONE;
		dp_widen_i = simd_fmt_pkg::WIDEN_PASS;
		dp_src_bits_i = '0;
		repeat (10) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		t_tag_word();
		t_operands();
		t_modes();
		t_clamps();
		final_report();
	end
endmodule : testbench
